// >>> hdl/ibc_sequencer.sv
// I2C master bus condition sequencer with AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Repeated start from idle drives clock low
// - Clock low: load reload<5:0>, release data
// - Timeout, data high: release clock, reload<6:0>
// - Data low one period, clear request
// - Start seen at once, flag after timeout
// - Repeated start ignored while busy
// - Collision on data low or clock drop
// - Buffer write during sequence sets collision flag
// - Lower five control bits locked meanwhile
// - Ack enable: clock low, present ack bit
// - Ack: period, release clock, period, low
// - Ack end clears enable, goes idle
// - Clock held low after ninth pulse
// - Stop: data low, count, clock, data up
// - Stop seen, period later flag set
module ibc_sequencer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic irq
);
    import ibc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] serial_data_buffer;
    logic [7:0] baud_reload_value;
    logic [7:0] serial_port_control_one;
    logic [7:0] serial_port_control_two;
    logic [7:0] serial_port_status;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic scl_m, scl_s, sda_m, sda_s, scl_p;
    logic [6:0] brg;
    logic brg_zero;
    ibc_state_e state;
    logic scl_drive_low, sda_drive_low;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_do, busy;
    logic ev_port, ev_bcol, ev_write_collision_flag, clr_rs, clr_ack, clr_stop;
    logic set_start, set_stop;

    assign brg_zero = (brg == 7'h00);
    assign busy = (state != IBC_IDLE);
    assign wr_do = aw_held && w_held && !s_axi_bvalid;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two stages per line; the second stage is read, and the clock keeps a third stage for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            scl_p <= 1'b1;
        end else if (clk_en) begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
            scl_p <= scl_s;
        end
    end

    // ------------------------------------------------------------
    // Condition sequencer
    // ------------------------------------------------------------
    // Walks repeated start, acknowledge and stop against the generator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= IBC_IDLE;
            brg <= 7'h00;
            scl_drive_low <= 1'b0;
            sda_drive_low <= 1'b0;
            ev_port <= 1'b0;
            ev_bcol <= 1'b0;
            clr_rs <= 1'b0;
            clr_ack <= 1'b0;
            clr_stop <= 1'b0;
            set_start <= 1'b0;
            set_stop <= 1'b0;
        end else if (clk_en) begin
            ev_port <= 1'b0;
            ev_bcol <= 1'b0;
            clr_rs <= 1'b0;
            clr_ack <= 1'b0;
            clr_stop <= 1'b0;
            set_start <= 1'b0;
            set_stop <= 1'b0;
            if (!brg_zero) begin
                brg <= brg - 7'h01;
            end
            case (state)
                IBC_IDLE: begin
                    if (clr_rs || clr_ack || clr_stop || ev_bcol) begin
                        state <= IBC_IDLE; // Request bit still clearing
                    end else if (serial_port_control_two[CT2_RSTART]) begin
                        scl_drive_low <= 1'b1;
                        state <= RS_LOW;
                    end else if (serial_port_control_two[CT2_ACK]) begin
                        scl_drive_low <= 1'b1;
                        sda_drive_low <= !serial_port_control_two[CT2_ACK_DATA_VALUE];
                        brg <= baud_reload_value[6:0];
                        state <= AK_LOW;
                    end else if (serial_port_control_two[CT2_STOP]) begin
                        sda_drive_low <= 1'b1;
                        scl_drive_low <= 1'b1;
                        state <= SP_SDA_LOW;
                    end
                end
                RS_LOW: begin
                    if (!scl_s) begin
                        brg <= {1'b0, baud_reload_value[5:0]};
                        sda_drive_low <= 1'b0;
                        state <= RS_SDA_UP;
                    end
                end
                RS_SDA_UP: begin
                    if (brg_zero && sda_s) begin
                        scl_drive_low <= 1'b0;
                        state <= RS_SCL_UP;
                    end
                end
                RS_SCL_UP: begin
                    if (scl_s) begin
                        if (!sda_s) begin
                            state <= IBC_IDLE;
                            ev_bcol <= 1'b1;
                        end else begin
                            brg <= baud_reload_value[6:0];
                            state <= RS_HIGH;
                        end
                    end
                end
                RS_HIGH: begin
                    if (!scl_s || !sda_s) begin
                        state <= IBC_IDLE;
                        ev_bcol <= 1'b1;
                    end else if (brg_zero) begin
                        sda_drive_low <= 1'b1;
                        brg <= baud_reload_value[6:0];
                        state <= RS_SDA_LOW;
                    end
                end
                RS_SDA_LOW: begin
                    if (!sda_s && scl_s && scl_p) begin
                        set_start <= 1'b1;
                    end
                    if (brg_zero) begin
                        clr_rs <= 1'b1;
                        ev_port <= 1'b1;
                        state <= IBC_IDLE;
                    end
                end
                AK_LOW: begin
                    if (brg_zero) begin
                        scl_drive_low <= 1'b0;
                        state <= AK_SCL_UP;
                    end
                end
                AK_SCL_UP: begin
                    if (scl_s) begin
                        brg <= baud_reload_value[6:0];
                        state <= AK_HIGH;
                    end
                end
                AK_HIGH: begin
                    if (brg_zero) begin
                        scl_drive_low <= 1'b1;
                        clr_ack <= 1'b1;
                        ev_port <= 1'b1;
                        brg <= 7'h00;
                        state <= IBC_IDLE;
                    end
                end
                SP_SDA_LOW: begin
                    if (!sda_s) begin
                        brg <= baud_reload_value[6:0];
                        state <= SP_WAIT;
                    end
                end
                SP_WAIT: begin
                    if (brg_zero) begin
                        scl_drive_low <= 1'b0;
                        brg <= baud_reload_value[6:0];
                        state <= SP_SCL_UP;
                    end
                end
                SP_SCL_UP: begin
                    if (brg_zero) begin
                        sda_drive_low <= 1'b0;
                        state <= SP_SDA_UP;
                    end
                end
                SP_SDA_UP: begin
                    if (sda_s && scl_s) begin
                        set_stop <= 1'b1;
                        brg <= baud_reload_value[6:0];
                        state <= SP_DONE;
                    end
                end
                SP_DONE: begin
                    if (brg_zero) begin
                        clr_stop <= 1'b1;
                        ev_port <= 1'b1;
                        state <= IBC_IDLE;
                    end
                end
                default: begin
                    state <= IBC_IDLE;
                end
            endcase
            // Clock pulled low by another party before data was asserted
            if ((state == RS_SDA_UP || state == RS_SCL_UP) && scl_p && !scl_s
                && !scl_drive_low) begin
                state <= IBC_IDLE;
                ev_bcol <= 1'b1;
            end
            if (ev_bcol) begin
                scl_drive_low <= 1'b0;
                sda_drive_low <= 1'b0;
                clr_rs <= 1'b1;
                brg <= 7'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers and AXI4-Lite slave
    // ------------------------------------------------------------
    // Write channel capture, either order accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr <= RST_BYTE;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_do) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr > OFS_IRQ_MASK || aw_addr[1:0] != 2'h0)
                    ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign aw_held = !s_axi_awready;
    assign w_held = !s_axi_wready;

    // Register writes and hardware updates; hardware set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_data_buffer <= RST_BYTE;
            baud_reload_value <= RST_RELOAD;
            serial_port_control_one <= RST_BYTE;
            serial_port_control_two <= RST_BYTE;
            serial_port_status <= RST_BYTE;
            irq_status <= RST_IRQ;
            irq_mask <= RST_IRQ;
            ev_write_collision_flag <= 1'b0;
        end else if (clk_en) begin
            ev_write_collision_flag <= 1'b0;
            if (wr_do && w_strb[0]) begin
                case (aw_addr)
                    OFS_BUFFER: begin
                        if (busy) begin
                            ev_write_collision_flag <= 1'b1;
                        end else begin
                            serial_data_buffer <= w_data[7:0];
                        end
                    end
                    OFS_RELOAD: baud_reload_value <= w_data[7:0];
                    OFS_CTRL_ONE: serial_port_control_one <= w_data[7:0];
                    OFS_CTRL_TWO: begin
                        if (busy) begin
                            serial_port_control_two <= (serial_port_control_two
                                & CT2_LOCK_MASK) | (w_data[7:0] & ~CT2_LOCK_MASK);
                        end else begin
                            serial_port_control_two <= w_data[7:0];
                        end
                    end
                    OFS_STATUS: serial_port_status <= w_data[7:0];
                    OFS_IRQ_STATUS: irq_status <= irq_status & ~w_data[2:0];
                    OFS_IRQ_MASK: irq_mask <= w_data[2:0];
                    default: begin
                    end
                endcase
            end
            if (clr_rs) serial_port_control_two[CT2_RSTART] <= 1'b0;
            if (clr_ack) serial_port_control_two[CT2_ACK] <= 1'b0;
            if (clr_stop) serial_port_control_two[CT2_STOP] <= 1'b0;
            if (ev_write_collision_flag) serial_port_control_one[CT1_WRITE_COLLISION_FLAG] <= 1'b1;
            if (set_start) begin
                serial_port_status[ST_START] <= 1'b1;
                serial_port_status[ST_STOP] <= 1'b0;
            end
            if (set_stop) begin
                serial_port_status[ST_STOP] <= 1'b1;
                serial_port_status[ST_START] <= 1'b0;
            end
            if (ev_port) irq_status[IRQ_PORT] <= 1'b1;
            if (ev_bcol) irq_status[IRQ_BCOL] <= 1'b1;
            if (ev_write_collision_flag) irq_status[IRQ_WRITE_COLLISION_FLAG] <= 1'b1;
        end
    end

    // Read channel, one register per word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr)
                    OFS_BUFFER: s_axi_rdata <= {24'h0, serial_data_buffer};
                    OFS_RELOAD: s_axi_rdata <= {24'h0, baud_reload_value};
                    OFS_CTRL_ONE: s_axi_rdata <= {24'h0, serial_port_control_one};
                    OFS_CTRL_TWO: s_axi_rdata <= {24'h0, serial_port_control_two};
                    OFS_STATUS: s_axi_rdata <= {24'h0, serial_port_status};
                    OFS_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_status};
                    OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers and interrupt
    // ------------------------------------------------------------
    // Open drain: drive low only, enable while pulling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            scl_oe <= scl_drive_low;
            sda_oe <= sda_drive_low;
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule

// >>> common/ibc_pkg.sv
// Package with register map, field positions and constants of the bus condition sequencer
package ibc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BUFFER = 8'h00;
    localparam logic [7:0] OFS_RELOAD = 8'h04;
    localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CT2_RSTART = 1;
    localparam int CT2_STOP = 2;
    localparam int CT2_ACK = 4;
    localparam int CT2_ACK_DATA_VALUE = 5;
    localparam int CT1_WRITE_COLLISION_FLAG = 7;
    localparam int ST_START = 3;
    localparam int ST_STOP = 4;
    localparam int IRQ_PORT = 0;
    localparam int IRQ_BCOL = 1;
    localparam int IRQ_WRITE_COLLISION_FLAG = 2;
    localparam logic [7:0] CT2_LOCK_MASK = 8'h1F;
    // ------------------------------------------------------------
    // Reset values and response codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_RELOAD = 8'h04;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        IBC_IDLE, RS_LOW, RS_SDA_UP, RS_SCL_UP, RS_HIGH, RS_SDA_LOW,
        AK_LOW, AK_SCL_UP, AK_HIGH, SP_SDA_LOW, SP_WAIT, SP_SCL_UP, SP_SDA_UP, SP_DONE
    } ibc_state_e;
endpackage

// >>> verification/ibc_props.sv
// Concurrent checks on the ports of the bus condition sequencer
`timescale 1ns/1ps
module ibc_props
import ibc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic irq
);
    // ----------------------------------------
    // Clocking for every check, reset for every check but the reset check
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Reset leaves both lines released and the interrupt and write response quiet
    property p_reset_quiet;
        disable iff (1'b0) !aresetn |=> !scl_oe && !sda_oe && !irq && !s_axi_bvalid;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    // Open-drain: the driven level is always low
    property p_drive_zero;
        scl_out == 1'b0 && sda_out == 1'b0;
    endproperty
    a_drive_zero: assert property (p_drive_zero) else $error("line driven high");
    // Data pulled low with clock released only while clock is high
    property p_start_edge;
        $rose(sda_oe) && !scl_oe |-> scl_in;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start edge with clock low");
    // Start condition keeps data low and clock released for a while
    property p_start_hold;
        $rose(sda_oe) && !scl_oe |=> (sda_oe && !scl_oe) [*2];
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start condition too short");
    // Data released with clock released only while clock is high
    property p_stop_edge;
        $fell(sda_oe) && !scl_oe |-> scl_in;
    endproperty
    a_stop_edge: assert property (p_stop_edge) else $error("stop edge with clock low");
    // A released clock stays released at least a couple of cycles
    property p_scl_release;
        $fell(scl_oe) |=> !scl_oe [*2];
    endproperty
    a_scl_release: assert property (p_scl_release) else $error("clock pulse too short");
    // Masking every source drops the interrupt
    property p_irq_mask;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
            && s_axi_awaddr == OFS_IRQ_MASK && s_axi_wdata[2:0] == 3'h0 |-> ##4 !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
    // Write response follows the taken address and data
    property p_bresp_time;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_bresp_time: assert property (p_bresp_time) else $error("write response late");
    // One response per write
    property p_bvalid_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bvalid_once: assert property (p_bvalid_once) else $error("write response repeated");
    // Read answer one to two cycles after the request is seen
    property p_read_answer;
        s_axi_arvalid && !s_axi_rvalid |-> ##[1:2] s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule

bind ibc_sequencer ibc_props chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_rvalid, .scl_in, .scl_out, .scl_oe, .sda_out,
    .sda_oe, .irq);

// >>> verification/ibc_bus_model.sv
// Open-drain two-wire bus with pull-ups and a far-side device that can stretch the clock
`timescale 1ns/1ps
module ibc_bus_model (
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic stretch,
    output logic scl_line,
    output logic sda_line
);
    // Wired-AND; a released line floats high through its pull-up
    assign scl_line = !(scl_oe || stretch);
    assign sda_line = !sda_oe;
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the bus condition sequencer
`timescale 1ns/1ps
module testbench;
import ibc_pkg::*;
logic aclk, aresetn, clk_en, stretch, irq;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic [31:0] s_axi_wdata, s_axi_rdata, rd;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
int n_mismatch = 0;
int check_count = 0;

ibc_sequencer dut_u (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .irq);
ibc_bus_model bus_u (.scl_oe, .sda_oe, .stretch, .scl_line(scl_in), .sda_line(sda_in));

// --------------------------------
// Clock, compare and verdict
// --------------------------------
initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
end
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
        $display("Simulation passed");
    end else begin
        $display("Simulation failed");
    end
    $finish;
endtask

// --------------------------------
// Register bus tasks
// --------------------------------
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, aw_done, w_done, b_hit;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_hit = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
        @(negedge aclk);
        aw_hit = s_axi_awvalid && s_axi_awready;
        w_hit = s_axi_wvalid && s_axi_wready;
        @(posedge aclk);
        if (aw_hit) begin
            s_axi_awvalid <= 1'b0;
            aw_done = 1'b1;
        end
        if (w_hit) begin
            s_axi_wvalid <= 1'b0;
            w_done = 1'b1;
        end
    end
    while (!b_hit) begin
        @(negedge aclk);
        b_hit = s_axi_bvalid;
        rsp = s_axi_bresp;
        @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
endtask
task automatic rd_reg(input logic [7:0] a);
    logic ar_hit, r_hit;
    r_hit = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hit) begin
        @(negedge aclk);
        ar_hit = s_axi_arvalid && s_axi_arready;
        r_hit = s_axi_rvalid;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
        if (ar_hit) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
endtask
task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_reg(a);
    check(rd & m, e);
endtask
// Read until a bit reaches the wanted value, bounded
task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    rd_reg(a);
    while (rd[b] !== v && n < 400) begin
        rd_reg(a);
        n++;
    end
    check({31'h0, rd[b]}, {31'h0, v});
endtask
// Wait for a line enable to reach a level, bounded
task automatic wait_line(input bit on_scl, input logic v);
    int n;
    n = 0;
    @(negedge aclk);
    while ((on_scl ? scl_oe : sda_oe) !== v && n < 300) begin
        @(negedge aclk);
        n++;
    end
    check({31'h0, on_scl ? scl_oe : sda_oe}, {31'h0, v});
endtask
task automatic chk_irq(input logic v);
    repeat (3) @(negedge aclk);
    check({31'h0, irq}, {31'h0, v});
endtask

// --------------------------------
// Watchdog and main sequence
// --------------------------------
initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    end_sim;
end
initial begin
    static logic [7:0] ofs [5] = '{OFS_BUFFER, OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_STATUS,
        OFS_IRQ_STATUS};
    {aresetn, stretch, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    clk_en = 1'b1;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and unmapped places
    chk_reg(OFS_RELOAD, 32'hFF, {24'h0, RST_RELOAD});
    foreach (ofs[i]) chk_reg(ofs[i], 32'hFF, {24'h0, RST_BYTE});
    rd_reg(8'h1C);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    check(rd, 32'h0);
    wr(8'h05, 32'h1);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFS_RELOAD, 32'h10);
    chk_reg(OFS_RELOAD, 32'hFF, 32'h10);
    wr(OFS_IRQ_MASK, 32'h7);
    // Repeated start with colliding register writes
    wr(OFS_CTRL_TWO, 32'h02);
    wait_line(1, 1'b1);
    wr(OFS_BUFFER, 32'hA5);
    wr(OFS_CTRL_TWO, 32'h10);
    chk_reg(OFS_CTRL_TWO, 32'h1F, 32'h02);
    chk_reg(OFS_CTRL_ONE, 32'h80, 32'h80);
    wait_line(1, 1'b0);
    wait_line(0, 1'b1);
    poll(OFS_CTRL_TWO, CT2_RSTART, 1'b0);
    check({31'h0, sda_oe}, 32'h1);
    chk_reg(OFS_STATUS, 32'h08, 32'h08);
    chk_reg(OFS_IRQ_STATUS, 32'h7, 32'h5);
    chk_reg(OFS_BUFFER, 32'hFF, 32'h0);
    chk_irq(1'b1);
    wr(OFS_IRQ_STATUS, 32'h7);
    chk_reg(OFS_IRQ_STATUS, 32'h7, 32'h0);
    chk_irq(1'b0);
    wr(OFS_BUFFER, 32'h5A);
    chk_reg(OFS_BUFFER, 32'hFF, 32'h5A);
    // Not-acknowledge then acknowledge, the far side stretching the clock
    for (int k = 1; k >= 0; k--) begin
        wr(OFS_CTRL_TWO, {26'h0, k[0], 5'h10});
        stretch <= 1'b1;
        wait_line(0, ~k[0]);
        check({31'h0, scl_oe}, 32'h1);
        wait_line(1, 1'b0);
        repeat (40) @(posedge aclk);
        chk_reg(OFS_CTRL_TWO, 32'h10, 32'h10);
        stretch <= 1'b0;
        poll(OFS_CTRL_TWO, CT2_ACK, 1'b0);
        check({31'h0, scl_oe}, 32'h1);
    end
    // Stop with the interrupt masked
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_CTRL_TWO, 32'h04);
    wait_line(0, 1'b1);
    wait_line(1, 1'b0);
    wait_line(0, 1'b0);
    poll(OFS_CTRL_TWO, CT2_STOP, 1'b0);
    chk_reg(OFS_STATUS, 32'h10, 32'h10);
    chk_reg(OFS_IRQ_STATUS, 32'h1, 32'h1);
    chk_irq(1'b0);
    wr(OFS_IRQ_MASK, 32'h7);
    chk_irq(1'b1);
    wr(OFS_IRQ_STATUS, 32'h1);
    chk_irq(1'b0);
    // Clock dragged low by another master during the start high phase
    wr(OFS_CTRL_TWO, 32'h02);
    wait_line(1, 1'b1);
    wait_line(1, 1'b0);
    repeat (6) @(posedge aclk);
    stretch <= 1'b1;
    repeat (12) @(negedge aclk);
    check({30'h0, scl_oe, sda_oe}, 32'h0);
    chk_reg(OFS_IRQ_STATUS, 32'h2, 32'h2);
    chk_irq(1'b1);
    end_sim;
end
endmodule
